//--- hw/cpust_pkg.sv
// Package for the processor status and bank select register
package cpust_pkg;

   // ****************************************
   // Register map and field layout
   // ****************************************
   localparam logic [7:0] CPUST_STATUS_OFS   = 8'h03;
   localparam logic [7:0] CPUST_EVENT_OFS    = 8'h04;
   localparam int         CPUST_BIT_IBANK    = 7;
   localparam int         CPUST_BIT_DBANK_HI = 6;
   localparam int         CPUST_BIT_DBANK_LO = 5;
   localparam int         CPUST_BIT_WDT_N    = 4;
   localparam int         CPUST_BIT_SLEEP_N  = 3;
   localparam int         CPUST_BIT_ZERO     = 2;
   localparam int         CPUST_BIT_NCARRY   = 1;
   localparam int         CPUST_BIT_CARRY    = 0;
   localparam logic [7:0] CPUST_RESET_VAL    = 8'h18;
   localparam logic [7:0] CPUST_RO_MASK      = 8'h18;
   localparam logic [7:0] CPUST_ARITH_MASK   = 8'h07;

   // ****************************************
   // Operation kinds and carriers
   // ****************************************
   typedef enum logic [3:0] {
      CPUST_OP_STORE,   // store_working_instr, plain write
      CPUST_OP_BITCLR,  // bit_clear_instr
      CPUST_OP_BITSET,  // bit_set_instr
      CPUST_OP_SWAP,    // nibble_swap_instr
      CPUST_OP_CLEAR,   // file_zero_instr
      CPUST_OP_ADD,
      CPUST_OP_SUB,
      CPUST_OP_LOGIC
   } cpust_op_e;

   typedef struct packed {
      logic       wdt_clear;
      logic       sleep;
      logic       wdt_timeout;
   } cpust_evt_s;

   typedef struct packed {
      logic       ibank;
      logic [1:0] dbank;
   } cpust_bank_s;

endpackage : cpust_pkg

//--- hw/cpust_reg.sv
// Processor status and bank select register with Avalon-MM access
`timescale 1ns/1ps
// Behaviour
// - Status register is an ordinary writable location
// - Flag-updating ops override written arithmetic flags
// - Writes to reset-cause flags are ignored
// - Clear op zeroes banks, sets zero flag
// - Bit, swap, store ops store value as written
// - Bits 6-5 select direct bank
// - Time-out flag set at power-up, clear-watchdog, sleep
// - Subtraction carries are inverted borrows
// - Reset: banks zero, cause flags one
//
// Write data [11:8] carries the operation kind, [7:0] the value or operand.
// Flag-updating ops use the stored value as first operand, data as second.
module cpust_reg
   import cpust_pkg::*;
(
   // Clock and reset
   input  wire logic                core_clk,
   input  wire logic                arst_n,
   // Avalon-MM slave
   input  wire logic [7:0]          address,
   input  wire logic                read,
   input  wire logic                write,
   input  wire logic [31:0]         writedata,
   output logic      [31:0]         readdata,
   output logic                     waitrequest,
   // Core events, asynchronous to the bus
   input  wire cpust_pkg::cpust_evt_s evt_in,
   // Bank selection to the address path
   output cpust_pkg::cpust_bank_s   bank_sel
);
   import cpust_pkg::*;

   // ****************************************
   // Event synchronisers and edge detect
   // ****************************************
   cpust_evt_s evt_s1, evt_s2, evt_s3;
   cpust_evt_s evt_pulse;

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         evt_s1 <= '0;
         evt_s2 <= '0;
         evt_s3 <= '0;
      end
      else
      begin
         evt_s1 <= evt_in;
         evt_s2 <= evt_s1;
         evt_s3 <= evt_s2;
      end
   end

   assign evt_pulse = evt_s2 & ~evt_s3;

   // ****************************************
   // Bus handshake
   // ****************************************
   // One wait cycle per access keeps read data straight from a flop
   logic acc_done;
   logic hit_status;
   logic [7:0] status;

   assign hit_status = (address == CPUST_STATUS_OFS);

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         acc_done <= 1'b0;
      else
         acc_done <= (read | write) & ~acc_done;
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         waitrequest <= 1'b1;
      else
         waitrequest <= ~((read | write) & ~acc_done);
   end

   logic wr_take;
   assign wr_take = write & acc_done & hit_status;

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         readdata <= 32'h0000_0000;
      else if (read & ~acc_done)
         readdata <= hit_status ? {24'h00_0000, status} : 32'h0000_0000;
   end

   // ****************************************
   // Instruction result and flag merge
   // ****************************************
   cpust_op_e  op;
   logic [7:0] opnd;
   logic [7:0] result;
   logic [7:0] next_status;
   logic       upd_z, upd_c;
   logic [8:0] sum;
   logic [4:0] nsum;

   assign op   = cpust_op_e'(writedata[11:8]);
   assign opnd = writedata[7:0];

   always_comb
   begin
      upd_z  = 1'b0;
      upd_c  = 1'b0;
      sum    = 9'h000;
      nsum   = 5'h00;
      result = opnd;
      case (op)
         CPUST_OP_STORE:  result = opnd;
         CPUST_OP_BITCLR: result = status & ~opnd;
         CPUST_OP_BITSET: result = status | opnd;
         CPUST_OP_SWAP:   result = {status[3:0], status[7:4]};
         CPUST_OP_CLEAR:
         begin
            result = 8'h00;
            upd_z  = 1'b1;
         end
         CPUST_OP_ADD:
         begin
            sum    = {1'b0, status} + {1'b0, opnd};
            nsum   = {1'b0, status[3:0]} + {1'b0, opnd[3:0]};
            result = sum[7:0];
            upd_z  = 1'b1;
            upd_c  = 1'b1;
         end
         CPUST_OP_SUB:
         begin
            // Carry set means no borrow
            sum    = {1'b0, status} + {1'b0, ~opnd} + 9'h001;
            nsum   = {1'b0, status[3:0]} + {1'b0, ~opnd[3:0]} + 5'h01;
            result = sum[7:0];
            upd_z  = 1'b1;
            upd_c  = 1'b1;
         end
         CPUST_OP_LOGIC:
         begin
            result = status & opnd;
            upd_z  = 1'b1;
         end
         default: result = opnd;
      endcase

      next_status = status;
      if (wr_take)
      begin
         // Reset-cause bits never take written data
         next_status = (result & ~CPUST_RO_MASK) | (status & CPUST_RO_MASK);
         if (upd_z)
         begin
            // Flag ops block all three written flags; untouched ones hold
            next_status[CPUST_BIT_NCARRY] = status[CPUST_BIT_NCARRY];
            next_status[CPUST_BIT_CARRY]  = status[CPUST_BIT_CARRY];
            next_status[CPUST_BIT_ZERO]   = (result == 8'h00);
         end
         if (upd_c)
         begin
            next_status[CPUST_BIT_NCARRY] = nsum[4];
            next_status[CPUST_BIT_CARRY]  = sum[8];
         end
      end
      // Hardware events win over any write
      if (evt_pulse.wdt_clear)
      begin
         next_status[CPUST_BIT_WDT_N]   = 1'b1;
         next_status[CPUST_BIT_SLEEP_N] = 1'b1;
      end
      if (evt_pulse.sleep)
      begin
         next_status[CPUST_BIT_WDT_N]   = 1'b1;
         next_status[CPUST_BIT_SLEEP_N] = 1'b0;
      end
      if (evt_pulse.wdt_timeout)
         next_status[CPUST_BIT_WDT_N]   = 1'b0;
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         status <= CPUST_RESET_VAL;
      else
         status <= next_status;
   end

   // ****************************************
   // Bank select outputs
   // ****************************************
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         bank_sel <= '0;
      else
      begin
         bank_sel.ibank <= next_status[CPUST_BIT_IBANK];
         bank_sel.dbank <= next_status[CPUST_BIT_DBANK_HI:CPUST_BIT_DBANK_LO];
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   cause_ro_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      wr_take && !(|evt_pulse) |=> status[4:3] == $past(status[4:3]))
      else $error("reset-cause bits changed by a write");

   clear_op_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      wr_take && op == CPUST_OP_CLEAR |=> status[7:5] == 3'b000 && status[2])
      else $error("clear op did not zero banks and set zero");

   store_op_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      wr_take && op == CPUST_OP_STORE |=>
      (status & ~CPUST_RO_MASK) == ($past(opnd) & ~CPUST_RO_MASK))
      else $error("store op not kept as written");

   bank_out_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      bank_sel == {status[7], status[6:5]})
      else $error("bank select disagrees with register");

   sleep_evt_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      evt_pulse.sleep && !evt_pulse.wdt_timeout |=> status[4] && !status[3])
      else $error("sleep event flags wrong");

   wdt_exp_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      evt_pulse.wdt_timeout |=> !status[4])
      else $error("watchdog expiry did not clear time-out");

   add_flag_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      wr_take && op == CPUST_OP_ADD |=>
      status[0] == (({1'b0, $past(status)} + {1'b0, $past(opnd)}) > 9'h0FF))
      else $error("add carry wrong");

   sub_flag_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      wr_take && op == CPUST_OP_SUB |=> status[0] == ($past(status) >= $past(opnd)))
      else $error("subtract borrow sense wrong");

   flag_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      wr_take && (op == CPUST_OP_CLEAR || op == CPUST_OP_LOGIC) |=>
      status[1:0] == $past(status[1:0]))
      else $error("zero-only op changed carry flags");

   bus_wait_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      $rose(read | write) |-> ##1 !waitrequest)
      else $error("bus answer not after one wait cycle");

endmodule : cpust_reg

//--- test/tb_top.sv
// Self-checking bench for the status and bank select register
`timescale 1ns/1ps
module tb_top;
   import cpust_pkg::*;
   // ****************
   // Signals
   // ****************
   logic        core_clk;
   logic        arst_n;
   logic [7:0]  address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic        waitrequest;
   cpust_evt_s  evt_in;
   cpust_bank_s bank_sel;
   int          n_fail;
   int          num_checks;
   logic [7:0]  exp_st;
   logic [31:0] rd32;

   cpust_reg i_dut (.core_clk(core_clk), .arst_n(arst_n), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .evt_in(evt_in), .bank_sel(bank_sel));

   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // ****************
   // Tasks
   // ****************
   task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask : check

   // Waitrequest is read just after the edge, so it is the value sampled there
   // A slave that never answers is caught by the watchdog
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      address   <= a;
      read      <= ~wr;
      write     <= wr;
      writedata <= d;
      do
         @(posedge core_clk);
      while (waitrequest !== 1'b0);
      rd32 = readdata;
      read  <= 1'b0;
      write <= 1'b0;
      @(posedge core_clk);
   endtask : bus

   function automatic logic [7:0] model(input logic [3:0] op, input logic [7:0] s,
                                        input logic [7:0] d);
      logic [8:0] r;
      logic       dc;
      logic       c;
      r  = {1'b0, d};
      dc = s[1];
      c  = s[0];
      case (op)
         4'h1: r = {1'b0, s & ~d};
         4'h2: r = {1'b0, s | d};
         4'h3: r = {1'b0, s[3:0], s[7:4]};
         4'h4: r = 9'h000;
         4'h5:
         begin
            r  = {1'b0, s} + {1'b0, d};
            dc = ({1'b0, s[3:0]} + {1'b0, d[3:0]}) > 5'h0F;
            c  = r[8];
         end
         4'h6:
         begin
            r  = {1'b0, s} - {1'b0, d};
            dc = s[3:0] >= d[3:0];
            c  = s >= d;
         end
         4'h7: r = {1'b0, s & d};
         default: r = {1'b0, d};
      endcase
      if (op >= 4'h4 && op <= 4'h7)
         r[2:0] = {(r[7:0] == 8'h00), dc, c};
      r[4:3] = s[4:3];
      return r[7:0];
   endfunction : model

   task automatic read_chk();
      bus(1'b0, CPUST_STATUS_OFS, 32'h0);
      check("status", {24'h0, exp_st}, rd32);
      check("bank_sel", {29'h0, exp_st[7:5]}, {29'h0, bank_sel});
   endtask : read_chk

   task automatic do_op(input logic [3:0] op, input logic [7:0] d);
      exp_st = model(op, exp_st, d);
      bus(1'b1, CPUST_STATUS_OFS, {20'h0, op, d});
      read_chk();
   endtask : do_op

   task automatic evt(input logic [2:0] e, input logic [1:0] cause);
      evt_in <= cpust_evt_s'(e);
      repeat (2) @(posedge core_clk);
      evt_in <= cpust_evt_s'(3'h0);
      repeat (5) @(posedge core_clk);
      exp_st[4:3] = cause;
      read_chk();
   endtask : evt

   task automatic do_reset();
      arst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      @(posedge core_clk);
      exp_st = CPUST_RESET_VAL;
   endtask : do_reset

   task automatic report_and_stop();
      if (n_fail == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop

   // ****************
   // Tests
   // ****************
   initial
   begin
      n_fail = 0;
      num_checks = 0;
      arst_n = 1'b0;
      address = 8'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
      evt_in = cpust_evt_s'(3'h0);
      do_reset();
      read_chk();
      evt(3'h1, {1'b0, exp_st[3]});
      do_op(4'h0, 8'hFF);
      evt(3'h4, 2'h3);
      evt(3'h2, 2'h2);
      do_op(4'h0, 8'h08);
      for (int i = 0; i < 8; i++)
         do_op(4'h0, {i[2:0], 5'h00});
      do_op(4'h2, 8'h05);
      do_op(4'h1, 8'h81);
      do_op(4'h3, 8'h00);
      do_op(4'h0, 8'hE3);
      do_op(4'h4, 8'hFF);
      do_op(4'h5, 8'h0F);
      do_op(4'h5, 8'hFE);
      do_op(4'h5, ~exp_st + 8'h01);
      do_op(4'h0, 8'h21);
      do_op(4'h6, 8'h22);
      do_op(4'h6, 8'h01);
      do_op(4'h6, 8'hFF);
      do_op(4'h7, 8'h00);
      bus(1'b1, CPUST_EVENT_OFS, 32'h0FF);
      bus(1'b0, CPUST_EVENT_OFS, 32'h0);
      check("unmapped", 32'h0, rd32);
      read_chk();
      do_reset();
      read_chk();
      report_and_stop();
   end

   // Whole run is under two hundred cycles
   initial
   begin
      #200000;
      n_fail++;
      report_and_stop();
   end
endmodule : tb_top
